// *** rtl/gosm_map.svh ***
// Register offsets, field positions and reset values of the pin output mux.
// Assumes inclusion by bare name from design files that need them.
`ifndef GOSM_MAP_SVH
`define GOSM_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses = 4 x index)
`define GOSM_PIN6_IDX 8'h16
`define GOSM_PIN7_IDX 8'h17
`define GOSM_STATUS_IDX 8'h20

// ==========================================================================
// Control register field positions
`define GOSM_SEL_HI 7
`define GOSM_SEL_LO 5
`define GOSM_SRC_HI 4
`define GOSM_SRC_LO 2
`define GOSM_VAL_BIT 1
`define GOSM_EN_BIT 0

// ==========================================================================
// Reset values
`define GOSM_CTL_RESET 8'h00
`define GOSM_UNMAPPED_DATA 32'h00000000

`endif

// *** rtl/gosm_pkg.sv ***
// Types shared by the pin output mux.
// Assumes nothing beyond a SystemVerilog compiler.
package gosm_pkg;

  // ========================================================================
  // Source group codes
  typedef enum logic [2:0] {
    GOSM_SRC_RX0 = 3'h0,
    GOSM_SRC_RX1 = 3'h1,
    GOSM_SRC_RX2 = 3'h2,
    GOSM_SRC_RX3 = 3'h3,
    GOSM_SRC_DEV = 3'h4,
    GOSM_SRC_RSV5 = 3'h5,
    GOSM_SRC_TX0 = 3'h6,
    GOSM_SRC_RSV7 = 3'h7
  } gosm_src_t;

  // Control register layout
  typedef struct packed {
    logic [2:0] signal_select;
    logic [2:0] source_group;
    logic register_level;
    logic drive_enable;
  } gosm_ctl_t;

  // Status of one receive port
  typedef struct packed {
    logic [3:0] remote_pins;
    logic lock;
    logic pass;
    logic frame_valid;
    logic line_valid;
    logic enabled;
  } gosm_rx_t;

  // Status of the transmit port
  typedef struct packed {
    logic [3:0] pass_select;
    logic frame_valid;
    logic line_valid;
    logic synchronized;
    logic interrupt;
  } gosm_tx_t;

  // Bus access state
  typedef enum logic [1:0] {
    GOSM_BUS_IDLE = 2'b00,
    GOSM_BUS_ACK = 2'b01
  } gosm_bus_state_t;

endpackage

// *** rtl/gosm_pin_select.sv ***
// Signal selector for one output pin, from its control fields.
// Assumes status inputs synchronous to the core clock.
`timescale 1ns/1ps

module gosm_pin_select
  import gosm_pkg::*;
(
  // Control fields
  input wire gosm_ctl_t ctl_i,
  // Status sources
  input wire gosm_rx_t [3:0] rx_i,
  input wire gosm_tx_t tx_i,
  input wire logic frame_sync_i,
  // Selected level
  output logic level_o
);

  // ==========================================================================
  // Source and select decode
  always_comb begin
    logic [3:0] lock_en;
    logic [3:0] pass_en;
    logic [3:0] pass_tx;
    lock_en = '0;
    pass_en = '0;
    pass_tx = '0;
    level_o = 1'b0;
    for (int i = 0; i < 4; i++) begin
      lock_en[i] = rx_i[i].lock & rx_i[i].enabled;
      pass_en[i] = rx_i[i].pass | ~rx_i[i].enabled; // Disabled ports do not block AND
      pass_tx[i] = rx_i[i].pass | ~tx_i.pass_select[i];
    end
    case (gosm_src_t'(ctl_i.source_group)) // R1 R13
      GOSM_SRC_RX0, GOSM_SRC_RX1, GOSM_SRC_RX2, GOSM_SRC_RX3: begin
        case (ctl_i.signal_select) // R3
          3'h0, 3'h1, 3'h2, 3'h3: level_o = rx_i[ctl_i.source_group[1:0]]
              .remote_pins[ctl_i.signal_select[1:0]];
          3'h4: level_o = rx_i[ctl_i.source_group[1:0]].lock;
          3'h5: level_o = rx_i[ctl_i.source_group[1:0]].pass;
          3'h6: level_o = rx_i[ctl_i.source_group[1:0]].frame_valid;
          default: level_o = rx_i[ctl_i.source_group[1:0]].line_valid;
        endcase
      end
      GOSM_SRC_DEV: begin
        case (ctl_i.signal_select)
          3'h0: level_o = ctl_i.register_level; // R4 R9 R11
          3'h1: level_o = |lock_en; // R4
          3'h2: level_o = |(pass_en & {rx_i[3].enabled, rx_i[2].enabled,
              rx_i[1].enabled, rx_i[0].enabled}); // R5
          3'h3: level_o = (&pass_en) & (|{rx_i[3].enabled, rx_i[2].enabled,
              rx_i[1].enabled, rx_i[0].enabled}); // R5
          3'h4: level_o = frame_sync_i; // R4
          default: level_o = 1'b0;
        endcase
      end
      GOSM_SRC_TX0: begin
        case (ctl_i.signal_select)
          3'h0: level_o = (&pass_tx) & (|tx_i.pass_select); // R6
          3'h1: level_o = |({rx_i[3].pass, rx_i[2].pass, rx_i[1].pass,
              rx_i[0].pass} & tx_i.pass_select); // R6
          3'h2: level_o = tx_i.frame_valid; // R6
          3'h3: level_o = tx_i.line_valid; // R6
          3'h4: level_o = tx_i.synchronized; // R7
          3'h5: level_o = tx_i.interrupt; // R8
          default: level_o = 1'b0; // R8
        endcase
      end
      default: level_o = 1'b0; // R1
    endcase
  end

endmodule

// *** rtl/gosm_top.sv ***
// Output mux and enables for general-purpose pins six and seven.
// Assumes an Avalon-MM master on the core clock; pin inputs synchronous.
//
// Behaviour
// R1 - Pin seven source 0-3 picks a receive port, 4 device status, 6 transmit port, 5/7 reserved.
// R2 - Pin seven control holds select in 7:5, source in 4:2, level in bit 1 and enable in bit 0.
// R3 - From a receive port, selects 0-3 give remote pins, 4-7 lock, pass, frame and line valid.
// R4 - With device status, select 0 gives register level, 1 OR of enabled locks, 4 frame sync.
// R5 - With device status, select 3 gives AND of enabled pass, and select 2 gives OR of pass; the mux ORs the pass of enabled ports only.
// R6 - With transmit source, selects 0-3 give pass AND, pass OR, frame valid and line valid.
// R7 - With transmit source, select 4 gives the multi-port synchronized flag.
// R8 - With transmit source, select 5 gives its interrupt; 6 and 7 drive low.
// R9 - Pin seven level bit is the pin level when the register value is chosen.
// R10 - Pin seven enable bit gates driving and resets to zero.
// R11 - Pin six level bit is the pin level when the register value is chosen.
// R12 - Pin six enable bit gates driving and resets to zero.
// R13 - Pin six source field in 4:2 uses the same encoding as pin seven.
// R14 - A pin with enable low is left undriven whatever its source and select.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "gosm_map.svh"

module gosm_top
  import gosm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // Status sources
  input wire gosm_rx_t [3:0] rx_status_i,
  input wire gosm_tx_t tx_status_i,
  input wire logic frame_sync_i,
  // Pins
  output logic pin6_level_o,
  output logic pin6_oe_o,
  output logic pin7_level_o,
  output logic pin7_oe_o
);

  // ==========================================================================
  // Declarations
  gosm_ctl_t pin6_ctl_reg;
  gosm_ctl_t pin7_ctl_reg;
  gosm_bus_state_t bus_state_reg;
  logic [31:0] rdata_next;
  logic hit_next;
  logic [7:0] word_idx;
  logic pin6_sel;
  logic pin7_sel;

  // Byte address to register index
  function automatic logic [7:0] reg_index(input logic [9:0] addr);
    reg_index = addr[9:2];
  endfunction

  assign word_idx = reg_index(avs_address_i);

  // ==========================================================================
  // Bus handshake: one wait cycle, then acknowledge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bus_state_reg <= GOSM_BUS_IDLE;
    end else if (bus_state_reg == GOSM_BUS_ACK) begin
      bus_state_reg <= GOSM_BUS_IDLE;
    end else if (avs_read_i || avs_write_i) begin
      bus_state_reg <= GOSM_BUS_ACK;
    end
  end

  // Wait request from a flop: low only in the cycle after a request is taken
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      case (bus_state_reg)
        GOSM_BUS_IDLE: avs_waitrequest_o <= !(avs_read_i || avs_write_i);
        default: avs_waitrequest_o <= 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // Control registers, written on the acknowledge edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin6_ctl_reg <= `GOSM_CTL_RESET; // R10 R12
      pin7_ctl_reg <= `GOSM_CTL_RESET;
    end else if (bus_state_reg == GOSM_BUS_ACK && avs_write_i && avs_byteenable_i[0]) begin
      if (word_idx == `GOSM_PIN6_IDX) begin
        pin6_ctl_reg <= avs_writedata_i[7:0]; // R13
      end
      if (word_idx == `GOSM_PIN7_IDX) begin
        pin7_ctl_reg <= avs_writedata_i[7:0]; // R2
      end
    end
  end

  // Read decode
  always_comb begin
    rdata_next = `GOSM_UNMAPPED_DATA;
    hit_next = 1'b1;
    case (word_idx)
      `GOSM_PIN6_IDX: rdata_next = {24'h000000, pin6_ctl_reg};
      `GOSM_PIN7_IDX: rdata_next = {24'h000000, pin7_ctl_reg}; // R2
      `GOSM_STATUS_IDX: rdata_next = {28'h0000000, pin7_oe_o, pin7_level_o,
          pin6_oe_o, pin6_level_o};
      default: hit_next = 1'b0;
    endcase
  end

  // Read data and response registered during the wait cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h00000000;
      avs_response_o <= 2'h0;
    end else if (bus_state_reg == GOSM_BUS_IDLE && (avs_read_i || avs_write_i)) begin
      avs_readdata_o <= avs_read_i ? rdata_next : 32'h00000000;
      avs_response_o <= hit_next ? 2'h0 : 2'h3; // Unmapped answers decode error
    end
  end

  // ==========================================================================
  // Signal selection per pin
  gosm_pin_select u_pin6_select (
    .ctl_i(pin6_ctl_reg),
    .rx_i(rx_status_i),
    .tx_i(tx_status_i),
    .frame_sync_i(frame_sync_i),
    .level_o(pin6_sel)
  );

  gosm_pin_select u_pin7_select (
    .ctl_i(pin7_ctl_reg),
    .rx_i(rx_status_i),
    .tx_i(tx_status_i),
    .frame_sync_i(frame_sync_i),
    .level_o(pin7_sel)
  );

  // ==========================================================================
  // Pin outputs registered; level forced low while not driving
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin6_level_o <= 1'b0;
      pin6_oe_o <= 1'b0;
      pin7_level_o <= 1'b0;
      pin7_oe_o <= 1'b0;
    end else begin
      pin6_oe_o <= pin6_ctl_reg.drive_enable; // R12 R14
      pin6_level_o <= pin6_ctl_reg.drive_enable & pin6_sel; // R11 R14
      pin7_oe_o <= pin7_ctl_reg.drive_enable; // R10 R14
      pin7_level_o <= pin7_ctl_reg.drive_enable & pin7_sel; // R9 R14
    end
  end

endmodule

// *** bench/gosm_top_properties.sv ***
// Checker of the pin output mux, bound to the top module.
// Assumes registers change only through acknowledged bus writes.
`timescale 1ns/1ps
`include "gosm_map.svh"
module gosm_top_checker
  import gosm_pkg::*;
(
  // Clock, reset and bus
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Sources and pins
  input wire gosm_rx_t [3:0] rx_status_i,
  input wire gosm_tx_t tx_status_i,
  input wire logic frame_sync_i,
  input wire logic pin6_level_o,
  input wire logic pin6_oe_o,
  input wire logic pin7_level_o,
  input wire logic pin7_oe_o
);
  logic [7:0] c6_reg, c7_reg;
  logic ack;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ========================================================================
  // Shadow control registers, loaded by acknowledged writes
  assign ack = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      c6_reg <= 8'h00;
      c7_reg <= 8'h00;
    end else if (ack && avs_address_i[9:2] == `GOSM_PIN6_IDX) begin
      c6_reg <= avs_writedata_i[7:0];
    end else if (ack && avs_address_i[9:2] == `GOSM_PIN7_IDX) begin
      c7_reg <= avs_writedata_i[7:0];
    end
  end
  // ========================================================================
  // Pins follow control and sources one register later
  a_oe7_follows: assert property (pin7_oe_o == $past(c7_reg[0]))
    else $error("pin7 enable wrong");
  a_oe6_follows: assert property (pin6_oe_o == $past(c6_reg[0]))
    else $error("pin6 enable wrong");
  a_p7_undriven: assert property (!pin7_oe_o |-> !pin7_level_o)
    else $error("pin7 level while undriven");
  a_p6_undriven: assert property (!pin6_oe_o |-> !pin6_level_o)
    else $error("pin6 level while undriven");
  a_p7_reg_level: assert property ($past(c7_reg[7:2] == 6'h04 && c7_reg[0])
    |-> pin7_level_o == $past(c7_reg[1])) else $error("pin7 register level wrong");
  a_p6_reg_level: assert property ($past(c6_reg[7:2] == 6'h04 && c6_reg[0])
    |-> pin6_level_o == $past(c6_reg[1])) else $error("pin6 register level wrong");
  a_p7_fsync: assert property ($past(c7_reg[7:2] == 6'h24 && c7_reg[0])
    |-> pin7_level_o == $past(frame_sync_i)) else $error("pin7 frame sync wrong");
  a_p7_rx_lock: assert property ($past(c7_reg[7:4] == 4'h8 && c7_reg[0])
    |-> pin7_level_o == $past(rx_status_i[c7_reg[3:2]].lock)) else $error("pin7 lock wrong");
  a_p7_tx_sync: assert property ($past(c7_reg[7:2] == 6'h26 && c7_reg[0])
    |-> pin7_level_o == $past(tx_status_i.synchronized)) else $error("pin7 sync wrong");
endmodule

bind gosm_top gosm_top_checker u_gosm_top_checker (.core_clk_i, .rst_n_i, .avs_address_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .rx_status_i,
  .tx_status_i, .frame_sync_i, .pin6_level_o, .pin6_oe_o, .pin7_level_o, .pin7_oe_o);

// *** bench/gosm_pin_sampler.sv ***
// Outside logic reading the two pins as wires.
// Assumes a pull-up on each pin, so an undriven pin reads high.
`timescale 1ns/1ps
module gosm_pin_sampler (
  // Pin drivers
  input wire logic p6_i,
  input wire logic e6_i,
  input wire logic p7_i,
  input wire logic e7_i,
  // Wire levels
  output logic w6_o,
  output logic w7_o
);
  // Pull-up wins while the device does not drive
  assign w6_o = e6_i ? p6_i : 1'b1;
  assign w7_o = e7_i ? p7_i : 1'b1;
endmodule

// *** bench/tb_gosm_top.sv ***
// Testbench of the pin output mux: bus writes, then pin checks.
// Assumes the design, checker and pin sampler compiled before it.
`timescale 1ns/1ps
module tb_gosm_top;
  import gosm_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, fs = 0, wt, l6, o6, l7, o7, w6, w7;
  logic [9:0] ad = '0;
  logic [31:0] wd = '0, rdat;
  logic [3:0] be = 4'hf;
  logic [1:0] rsp;
  logic [8:0] m;
  gosm_rx_t [3:0] rx = '0;
  gosm_tx_t tx = '0;
  int fail_count = 0, checked = 0, i, s;
  always #10 clk = ~clk;
  gosm_top u_gosm_top (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(ad), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .avs_response_o(rsp), .rx_status_i(rx), .tx_status_i(tx),
    .frame_sync_i(fs), .pin6_level_o(l6), .pin6_oe_o(o6), .pin7_level_o(l7), .pin7_oe_o(o7));
  gosm_pin_sampler u_gosm_pin_sampler (.p6_i(l6), .e6_i(o6), .p7_i(l7), .e7_i(o7),
    .w6_o(w6), .w7_o(w7));
  // ========================================================================
  // Compare, verdict and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    rd <= 0;
    wr <= 0;
    if (n >= 20) begin
      fail_count++;
      conclude;
    end
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
    bus(0, a, 8'h00);
    chk(rdat, e);
    chk({30'h0, rsp}, {30'h0, r});
  endtask
  // Pins settle one register after control: {oe7,lvl7,wire7,oe6,lvl6,wire6}
  task automatic look(input logic [5:0] e);
    repeat (2) @(posedge clk);
    chk({26'h0, o7, l7, w7, o6, l6, w6}, {26'h0, e});
  endtask
  // ========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rdc(10'h5c, 32'h0, 2'b00);
    rdc(10'h58, 32'h0, 2'b00);
    bus(1, 10'h5c, 8'h13); look(6'b111001);
    rdc(10'h5c, 32'h13, 2'b00);
    bus(1, 10'h5c, 8'h11); look(6'b100001);
    fs <= 1; bus(1, 10'h5c, 8'h91); look(6'b111001);
    fs <= 0; look(6'b100001);
    rx <= {9'h018, 9'h018, 9'h011, 9'h009};
    for (s = 1; s < 8; s++) begin
      bus(1, 10'h5c, {s[2:0], 5'h11}); look({1'b1, {2{s < 3}}, 3'b001});
    end
    for (i = 0; i < 64; i++) begin
      s = (i / 2) % 8;
      m = 9'h1 << (s < 4 ? 5 + s : 8 - s);
      rx <= i % 2 ? '0 : '1;
      rx[i / 16] <= i % 2 ? m : ~m;
      bus(1, 10'h5c, {s[2:0], 1'b0, i[5:4], 2'b01}); look({1'b1, {2{i[0]}}, 3'b001});
    end
    for (i = 0; i < 16; i++) begin
      s = i % 8;
      tx <= i < 8 ? 8'h3f : 8'h30;
      rx <= i < 8 ? 36'h8 : 36'h1008;
      bus(1, 10'h5c, {s[2:0], 5'h19}); look({1'b1, {2{1'(16'h033e >> i)}}, 3'b001});
    end
    rx <= '1; tx <= '1; fs <= 1;
    for (i = 0; i < 16; i++) begin
      bus(1, 10'h5c, {i[2:0], 1'b1, i[3], 3'b111}); look(6'b100001);
    end
    bus(1, 10'h5c, 8'h12); look(6'b001001);
    bus(1, 10'h58, 8'h13); look(6'b001111);
    bus(1, 10'h58, 8'h11); look(6'b001100);
    bus(1, 10'h58, 8'h12); look(6'b001001);
    rx <= 36'h0;
    rx[2] <= 9'h010; bus(1, 10'h58, 8'h89); look(6'b001111);
    rdc(10'h80, 32'h3, 2'b00);
    be <= 4'h0; bus(1, 10'h58, 8'h00); be <= 4'hf;
    rdc(10'h58, 32'h89, 2'b00);
    rdc(10'h3fc, 32'h0, 2'b11);
    conclude;
  end
endmodule
